// File: rtl/address_extension_mmu.sv
// Overview of operation
// - widen 16-bit virtual address to 22-bit physical by six upper bits
// - non-dma data-memory accesses use page translation from the data page registers
// - top two bits pick page register; its 8 bits form a21-14
// - page 0..3 serve 0000-3fff, 4000-7fff, 8000-bfff, c000-ffff
// - segment translation: 6-bit segment is a21-16, virtual address below
// - fetches and program-memory data accesses use the code segment
// - in-service fetches and program-memory data accesses use the interrupt segment register while segment-save is off
// - dma uses dma segment when select bit set, else interrupt segment
// - code segment holds bits 5:0 only, upper bits zero, resets to 00h
// - far jump/call load code segment; far return restores it from stack
// - remap bit moves page registers to r224-227, ports to r240-243
// - seven translation registers readable and writable on page 21
// - locations beyond small internal memory in a segment stay unused
// - segment-save: interrupt pushes and reloads code segment, return restores
module address_extension_mmu (
    input wire logic i_clk,
    input wire logic i_reset,
    // register file port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [5:0] i_page_ptr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_hit,
    output logic o_port_remap,
    // core control
    input wire logic i_far_load,
    input wire logic i_far_restore,
    input wire logic [5:0] i_segment_value,
    input wire logic i_intr_entry,
    input wire logic i_intr_return,
    output logic o_segment_push,
    output logic [5:0] o_segment_pushed,
    // access request
    input wire logic i_req,
    input wire logic [15:0] i_vaddr,
    input wire logic i_fetch,
    input wire logic i_prog_data,
    input wire logic i_in_service,
    input wire logic i_dma,
    input wire logic i_dma_segment_select,
    output logic o_req,
    output logic [21:0] o_paddr
);
    import mmu_pkg::*;

    typedef struct packed {
        logic [3:0][PAGE_W-1:0] data_page;
        logic [SEG_W-1:0] code_segment;
        logic [SEG_W-1:0] interrupt_segment;
        logic [SEG_W-1:0] dma_segment;
        logic segment_save_enable;
        logic page_register_remap;
        logic [7:0] rdata;
        logic hit;
        logic push;
        logic [SEG_W-1:0] pushed;
        logic req;
        logic [PHYS_W-1:0] paddr;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic on_page;
    logic dpr_hit;
    logic [1:0] dpr_idx;
    logic [7:0] ext_mode_2;
    xlate_e mode;
    logic [SEG_W-1:0] seg;

    // mode and segment selection are purely combinational; the physical address is formed into a register
    always_comb begin
        on_page = (i_page_ptr == MMU_PAGE);
        ext_mode_2 = EXT_MODE_2_RESET;
        ext_mode_2[SEGMENT_SAVE_BIT] = s_q.segment_save_enable;
        ext_mode_2[PAGE_REMAP_BIT] = s_q.page_register_remap;
        if (s_q.page_register_remap) begin
            dpr_hit = (i_reg_addr[7:2] == ADDR_REMAP_BASE[7:2]);
        end else begin
            dpr_hit = on_page && (i_reg_addr[7:2] == ADDR_DATA_PAGE_0[7:2]);
        end
        dpr_idx = i_reg_addr[1:0];
        if (i_dma) begin
            mode = XL_DMA;
        end else if (i_fetch || i_prog_data) begin
            mode = (i_in_service && !s_q.segment_save_enable) ? XL_INTR : XL_CODE;
        end else begin
            mode = XL_PAGE;
        end
        case (mode)
            XL_CODE: seg = s_q.code_segment;
            XL_INTR: seg = s_q.interrupt_segment;
            XL_DMA: seg = i_dma_segment_select ? s_q.dma_segment : s_q.interrupt_segment;
            default: seg = s_q.code_segment;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.hit = 1'b0;
        s_d.rdata = 8'h00;
        s_d.req = i_req;
        if (mode == XL_PAGE) begin
            s_d.paddr = {s_q.data_page[i_vaddr[15:14]], i_vaddr[PAGE_OFS_W-1:0]};
        end else begin
            // full segment offset, no size clipping
            s_d.paddr = {seg, i_vaddr};
        end
        if (i_reg_rd) begin
            s_d.hit = 1'b1;
            if (dpr_hit) begin
                s_d.rdata = s_q.data_page[dpr_idx];
            end else if (on_page && i_reg_addr == ADDR_CODE_SEGMENT) begin
                s_d.rdata = {2'b00, s_q.code_segment};
            end else if (on_page && i_reg_addr == ADDR_INTERRUPT_SEGMENT) begin
                s_d.rdata = {2'b00, s_q.interrupt_segment};
            end else if (on_page && i_reg_addr == ADDR_DMA_SEGMENT) begin
                s_d.rdata = {2'b00, s_q.dma_segment};
            end else if (on_page && i_reg_addr == ADDR_EXT_MODE_2) begin
                s_d.rdata = ext_mode_2;
            end else begin
                s_d.hit = 1'b0;
            end
        end
        if (i_reg_wr) begin
            if (dpr_hit) begin
                s_d.data_page[dpr_idx] = i_reg_wdata;
            end else if (on_page && i_reg_addr == ADDR_CODE_SEGMENT) begin
                s_d.code_segment = i_reg_wdata[SEG_W-1:0];
            end else if (on_page && i_reg_addr == ADDR_INTERRUPT_SEGMENT) begin
                s_d.interrupt_segment = i_reg_wdata[SEG_W-1:0];
            end else if (on_page && i_reg_addr == ADDR_DMA_SEGMENT) begin
                s_d.dma_segment = i_reg_wdata[SEG_W-1:0];
            end else if (on_page && i_reg_addr == ADDR_EXT_MODE_2) begin
                s_d.segment_save_enable = i_reg_wdata[SEGMENT_SAVE_BIT];
                s_d.page_register_remap = i_reg_wdata[PAGE_REMAP_BIT];
            end
        end
        if (i_far_load || i_far_restore) begin
            s_d.code_segment = i_segment_value;
        end
        if (i_intr_entry && s_q.segment_save_enable) begin
            s_d.push = 1'b1;
            s_d.pushed = s_q.code_segment;
            s_d.code_segment = s_q.interrupt_segment;
        end
        if (i_intr_return && s_q.segment_save_enable) begin
            s_d.code_segment = i_segment_value;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_q.data_page <= {4{PAGE_RESET}};
            s_q.code_segment <= CODE_SEGMENT_RESET[SEG_W-1:0];
            s_q.interrupt_segment <= SEGMENT_RESET;
            s_q.dma_segment <= SEGMENT_RESET;
            s_q.segment_save_enable <= EXT_MODE_2_RESET[SEGMENT_SAVE_BIT];
            s_q.page_register_remap <= EXT_MODE_2_RESET[PAGE_REMAP_BIT];
            s_q.rdata <= 8'h00;
            s_q.hit <= 1'b0;
            s_q.push <= 1'b0;
            s_q.pushed <= SEGMENT_RESET;
            s_q.req <= 1'b0;
            s_q.paddr <= 22'h000000;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_reg_rdata = s_q.rdata;
    assign o_reg_hit = s_q.hit;
    assign o_port_remap = s_q.page_register_remap;
    assign o_segment_push = s_q.push;
    assign o_segment_pushed = s_q.pushed;
    assign o_req = s_q.req;
    assign o_paddr = s_q.paddr;

endmodule

// File: rtl/mmu_pkg.sv
package mmu_pkg;

    // register file addresses (group f, page 21 unless remapped)
    localparam logic [7:0] ADDR_DATA_PAGE_0 = 8'hf0;
    localparam logic [7:0] ADDR_DATA_PAGE_1 = 8'hf1;
    localparam logic [7:0] ADDR_DATA_PAGE_2 = 8'hf2;
    localparam logic [7:0] ADDR_DATA_PAGE_3 = 8'hf3;
    localparam logic [7:0] ADDR_CODE_SEGMENT = 8'hf4;
    localparam logic [7:0] ADDR_EXT_MODE_2 = 8'hf6;
    localparam logic [7:0] ADDR_INTERRUPT_SEGMENT = 8'hf8;
    localparam logic [7:0] ADDR_DMA_SEGMENT = 8'hf9;
    localparam logic [7:0] ADDR_REMAP_BASE = 8'he0;
    localparam logic [5:0] MMU_PAGE = 6'h15;

    // extended mode register 2 fields
    localparam int SEGMENT_SAVE_BIT = 6;
    localparam int PAGE_REMAP_BIT = 5;

    localparam logic [7:0] CODE_SEGMENT_RESET = 8'h00;
    localparam logic [7:0] EXT_MODE_2_RESET = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [5:0] SEGMENT_RESET = 6'h00;

    localparam int VIRT_W = 16;
    localparam int PHYS_W = 22;
    localparam int PAGE_OFS_W = 14;
    localparam int SEG_W = 6;
    localparam int PAGE_W = 8;

    typedef enum logic [1:0] {
        XL_PAGE = 2'b00,
        XL_CODE = 2'b01,
        XL_INTR = 2'b10,
        XL_DMA = 2'b11
    } xlate_e;

endpackage

// File: test/address_extension_mmu_bench.sv
module address_extension_mmu_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import mmu_pkg::*;
    logic i_clk = 0, i_reset = 1, fl = 0, fr = 0, ie = 0, ir = 0, rq = 0;
    logic fe = 0, pd = 0, sv = 0, dm = 0, ds = 0, wr, rd, hit, rmp, psh, oq;
    logic [7:0] ad, wd, rdat, got;
    logic [5:0] pp, pshv, sg = 0;
    logic [15:0] va = 0;
    logic [21:0] pa;
    int failures = 0, samples_checked = 0;
    address_extension_mmu u_address_extension_mmu (.i_clk(i_clk), .i_reset(i_reset),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(ad), .i_page_ptr(pp), .i_reg_wdata(wd),
        .o_reg_rdata(rdat), .o_reg_hit(hit), .o_port_remap(rmp), .i_far_load(fl),
        .i_far_restore(fr), .i_segment_value(sg), .i_intr_entry(ie), .i_intr_return(ir),
        .o_segment_push(psh), .o_segment_pushed(pshv), .i_req(rq), .i_vaddr(va),
        .i_fetch(fe), .i_prog_data(pd), .i_in_service(sv), .i_dma(dm),
        .i_dma_segment_select(ds), .o_req(oq), .o_paddr(pa));
    mmu_core_model u_mmu_core_model (.i_clk(i_clk), .o_reg_wr(wr), .o_reg_rd(rd),
        .o_reg_addr(ad), .o_page_ptr(pp), .o_reg_wdata(wd), .i_reg_rdata(rdat));
    initial forever #5 i_clk = ~i_clk;
    task automatic chk(string n, logic [21:0] s, logic [21:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdc(logic [7:0] a, logic [5:0] p, logic [7:0] e);
        u_mmu_core_model.rd(a, p, got);
        chk("rdata", got, e);
    endtask
    task automatic acc(logic [15:0] v, logic [4:0] m, logic [21:0] e);
        @(posedge i_clk) #1 {fe, pd, sv, dm, ds} = m;
        rq = 1;
        va = v;
        @(posedge i_clk) #1 rq = 0;
        chk("paddr", {oq, pa}, {1'b1, e});
    endtask
    task automatic pls(ref logic s, input logic [5:0] v);
        @(posedge i_clk) #1 s = 1;
        sg = v;
        @(posedge i_clk) #1 s = 0;
    endtask
    task automatic t_pages;
        for (int i = 0; i < 10; i++) if (i != 5 && i != 7) rdc(8'hf0 + 8'(i), MMU_PAGE, 8'h00);
        for (int i = 0; i < 4; i++) u_mmu_core_model.wr(8'hf0 + 8'(i), MMU_PAGE, 8'h3c * 8'(i + 1));
        u_mmu_core_model.wr(ADDR_INTERRUPT_SEGMENT, MMU_PAGE, 8'hff);
        u_mmu_core_model.wr(ADDR_DMA_SEGMENT, MMU_PAGE, 8'hea);
        rdc(ADDR_INTERRUPT_SEGMENT, MMU_PAGE, 8'h3f);
        rdc(ADDR_DATA_PAGE_3, MMU_PAGE, 8'hf0);
        for (int i = 0; i < 4; i++) begin
            acc(16'(i) << 14, 5'b0, {8'h3c * 8'(i + 1), 14'h0});
            acc((16'(i) << 14) | 16'h3fff, 5'b0, {8'h3c * 8'(i + 1), 14'h3fff});
        end
    endtask
    task automatic t_segs;
        acc(16'h1234, 5'b10000, {6'h00, 16'h1234});
        pls(fl, 6'h2d);
        acc(16'hfedc, 5'b10000, {6'h2d, 16'hfedc});
        acc(16'h8001, 5'b01000, {6'h2d, 16'h8001});
        acc(16'h0042, 5'b10100, {6'h3f, 16'h0042});
        acc(16'h7777, 5'b00011, {6'h2a, 16'h7777});
        acc(16'h7777, 5'b00010, {6'h3f, 16'h7777});
        rdc(ADDR_CODE_SEGMENT, MMU_PAGE, 8'h2d);
        pls(fr, 6'h11);
        acc(16'hffff, 5'b10000, {6'h11, 16'hffff});
    endtask
    task automatic t_save;
        u_mmu_core_model.wr(ADDR_EXT_MODE_2, MMU_PAGE, 8'h40);
        pls(ie, 6'h00);
        chk("push", {psh, pshv}, {1'b1, 6'h11});
        acc(16'h0100, 5'b10100, {6'h3f, 16'h0100});
        pls(ir, 6'h11);
        acc(16'h0100, 5'b10000, {6'h11, 16'h0100});
    endtask
    task automatic t_remap;
        u_mmu_core_model.wr(ADDR_EXT_MODE_2, MMU_PAGE, 8'h20);
        rdc(ADDR_EXT_MODE_2, MMU_PAGE, 8'h20);
        chk("remap", rmp, 1'b1);
        u_mmu_core_model.wr(8'he1, 6'h00, 8'h55);
        rdc(8'he1, 6'h02, 8'h55);
        rdc(ADDR_DATA_PAGE_1, MMU_PAGE, 8'h00);
        acc(16'h4abc, 5'b0, {8'h55, 14'h0abc});
        rdc(8'h10, MMU_PAGE, 8'h00);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        #1 i_reset = 0;
        t_pages;
        t_segs;
        t_save;
        t_remap;
        stop_test;
    end
    initial begin
        #20000;
        failures++;
        stop_test;
    end
endmodule

// File: test/address_extension_mmu_chk.sv
module mmu_chk (
    input wire logic i_clk, i_reset, i_reg_rd, i_far_load, i_intr_entry, i_intr_return,
    input wire logic i_req, i_fetch, i_prog_data, i_in_service, i_dma,
    input wire logic [7:0] i_reg_addr,
    input wire logic [5:0] i_page_ptr, i_segment_value,
    input wire logic [15:0] i_vaddr,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_hit, o_segment_push, o_req,
    input wire logic [21:0] o_paddr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire seg = i_fetch | i_prog_data | i_dma;
    a_page_offset: assert property (
        !i_reset && i_req && !seg |=> o_req && o_paddr[13:0] == $past(i_vaddr[13:0]))
        else $error("page offset not passed through");
    a_segment_low: assert property (
        !i_reset && i_req && seg |=> o_req && o_paddr[15:0] == $past(i_vaddr))
        else $error("segment low bits wrong");
    a_far_segment: assert property (
        !i_reset && i_far_load && !i_intr_entry && !i_intr_return
        ##2 i_req && i_fetch && !i_dma && !i_in_service && !i_intr_entry
        |=> o_paddr[21:16] == $past(i_segment_value, 3))
        else $error("far load segment not used");
    a_unmapped_read: assert property (
        !i_reset && i_reg_rd && i_reg_addr < 8'he0 |=> !o_reg_hit && o_reg_rdata == 8'h00)
        else $error("unmapped read answered");
    a_segment_read: assert property (
        !i_reset && i_reg_rd && i_page_ptr == 6'h15 && i_reg_addr inside {8'hf4, 8'hf8, 8'hf9}
        |=> o_reg_hit && o_reg_rdata[7:6] == 2'b00)
        else $error("segment read wrong");
    a_idle_read: assert property (
        !i_reset && !i_reg_rd |=> !o_reg_hit && o_reg_rdata == 8'h00)
        else $error("read data without read");
    a_hit_cause: assert property (
        o_reg_hit |-> $past(i_reg_rd) && !$past(i_reset))
        else $error("hit without read");
    a_push_cause: assert property (
        o_segment_push |-> $past(i_intr_entry))
        else $error("push without interrupt entry");
endmodule
bind address_extension_mmu mmu_chk u_chk (.*);

// File: test/mmu_core_model.sv
module mmu_core_model (
    input wire logic i_clk,
    output logic o_reg_wr = 0,
    output logic o_reg_rd = 0,
    output logic [7:0] o_reg_addr = 8'h00,
    output logic [5:0] o_page_ptr = 6'h00,
    output logic [7:0] o_reg_wdata = 8'h00,
    input wire logic [7:0] i_reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic wr(logic [7:0] a, logic [5:0] p, logic [7:0] d);
        @(posedge i_clk) #1 {o_reg_wr, o_reg_addr, o_page_ptr, o_reg_wdata} = {1'b1, a, p, d};
        @(posedge i_clk) #1 o_reg_wr = 0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask
    task automatic rd(logic [7:0] a, logic [5:0] p, output logic [7:0] d);
        @(posedge i_clk) #1 {o_reg_rd, o_reg_addr, o_page_ptr} = {1'b1, a, p};
        @(posedge i_clk) #1 o_reg_rd = 0;
        d = i_reg_rdata;
        o_reg_addr = ~a;
    endtask
endmodule
